//--- bench/backplane_node_id_and_csr_tb_top.sv
// Self-checking bench for the node identification and control/status registers.
`timescale 1ns/100ps
module backplane_node_id_and_csr_tb_top;
  logic mclk, mrst_n, stop_cmd, iface_dc_low_line_n, selftest_reload, bus_drivers_en;
  logic fault, hirq, sirq, ipass, ppass, ce;
  logic [1:0] grant;
  logic [2:0] ev_req;
  logic [3:0] info;
  logic [14:0] herr;
  logic [2:0] serr;
  bnic_pkg::bnic_req_s req;
  bnic_pkg::bnic_rsp_s rsp;
  bnic_pkg::bnic_mst_s mst;
  int miscompares, cmp_count, cyc, n;
  logic [31:0] q;
  logic [1:0] vk;
  bnic_csr u_dut (.mclk(mclk), .mrst_n(mrst_n), .ce(ce), .req(req), .rsp(rsp), .mst(mst),
    .hard_err_bits(herr), .soft_err_bits(serr), .iface_selftest_pass(ipass),
    .port_selftest_pass(ppass), .stop_cmd(stop_cmd), .iface_info_lines(info),
    .iface_dc_low_line_n(iface_dc_low_line_n), .selftest_reload(selftest_reload),
    .bus_drivers_en(bus_drivers_en), .interlock_sequence_fault(fault),
    .hard_err_irq_req(hirq), .soft_err_irq_req(sirq), .bus_grant_scheme(grant));
  bnic_master_model u_mst (.mclk(mclk), .mrst_n(mrst_n), .selftest_reload(selftest_reload),
    .ev_req(ev_req), .mst(mst), .iface_selftest_pass(ipass), .port_selftest_pass(ppass));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic complete_run;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Request is held from one edge to the next, then the registered answer is sampled.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{1'b1, w, a, d};
    @(posedge mclk);
    req <= '0;
    @(negedge mclk);
    q = rsp.rdata;
    vk = {rsp.valid, rsp.ack};
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    acc(1'b0, a, 32'h0);
    chk("read answer", {30'h0, vk}, 32'h3);
    chk(nm, q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    acc(1'b1, a, d);
    chk("write answer", {30'h0, vk}, {30'h0, e});
  endtask
  task automatic pulse_ev(input logic [2:0] e);
    @(posedge mclk);
    ev_req <= e;
    @(posedge mclk);
    ev_req <= 3'h0;
  endtask
  function automatic logic [31:0] img(logic p, logic [1:0] s, logic u, logic [1:0] ie,
    logic [1:0] g, logic [3:0] id);
    return {bnic_pkg::IFACE_REVISION, bnic_pkg::IFACE_TYPE_CODE, s, 2'b00, p, 2'b00, u, ie,
      g, id};
  endfunction
  initial begin
    mrst_n = 1'b0;
    req = '0;
    ce = 1'b1;
    stop_cmd = 1'b0;
    ev_req = 3'h0;
    info = 4'ha;
    herr = 15'h0;
    serr = 3'h0;
    repeat (16) @(posedge mclk);
    mrst_n <= 1'b1;
    repeat (40) @(posedge mclk);
    rd(8'h00, {3'b000, 5'h00, 8'h00, bnic_pkg::NODE_TYPE_CODE}, "type");
    wr(8'h00, 32'hffff_ffff, 2'b11);
    rd(8'h00, {3'b110, 5'h1f, 8'hff, bnic_pkg::NODE_TYPE_CODE}, "type rw");
    rd(8'h04, img(1'b1, 2'b00, 1'b0, 2'b00, 2'b00, 4'ha), "csr boot");
    chk("drivers", {31'h0, bus_drivers_en}, 32'h1);
    wr(8'h04, 32'h0000_2a00, 2'b11);
    rd(8'h04, img(1'b1, 2'b00, 1'b0, 2'b00, 2'b00, 4'ha), "csr mbz");
    acc(1'b0, 8'h08, 32'h0);
    chk("unmapped", {30'h0, vk}, 32'h2);
    wr(8'h04, 32'h0000_08c0, 2'b11);
    @(posedge mclk);
    herr <= 15'h0400;
    serr <= 3'h2;
    rd(8'h04, img(1'b1, 2'b11, 1'b0, 2'b11, 2'b00, 4'ha), "csr errs");
    chk("irq", {30'h0, hirq, sirq}, 32'h3);
    @(posedge mclk);
    herr <= 15'h0;
    serr <= 3'h0;
    @(posedge mclk);
    stop_cmd <= 1'b1;
    @(posedge mclk);
    stop_cmd <= 1'b0;
    rd(8'h04, img(1'b1, 2'b00, 1'b0, 2'b00, 2'b00, 4'ha), "csr stop");
    chk("irq off", {30'h0, hirq, sirq}, 32'h0);
    for (int g = 0; g < 4; g++) begin
      wr(8'h04, 32'h0000_0800 | (g << 4), 2'b11);
      rd(8'h04, img(1'b1, 2'b00, 1'b0, 2'b00, g[1:0], 4'ha), "csr grant");
      chk("grant", {30'h0, grant}, g);
    end
    wr(8'h04, 32'h0000_0800, 2'b11);
    pulse_ev(3'h4);
    n = 0;
    repeat (6) begin
      @(negedge mclk);
      n += int'(fault === 1'b1);
    end
    chk("seq fault", n, 1);
    pulse_ev(3'h1);
    rd(8'h04, img(1'b1, 2'b00, 1'b1, 2'b00, 2'b00, 4'ha), "csr locked");
    pulse_ev(3'h2);
    rd(8'h04, img(1'b1, 2'b00, 1'b0, 2'b00, 2'b00, 4'ha), "csr unlocked");
    pulse_ev(3'h1);
    wr(8'h04, 32'h0000_0900, 2'b11);
    rd(8'h04, img(1'b1, 2'b00, 1'b0, 2'b00, 2'b00, 4'ha), "csr w1c");
    // An interlocked read that lands while the clock enable is low must be lost.
    @(posedge mclk);
    ce <= 1'b0;
    pulse_ev(3'h1);
    repeat (2) @(posedge mclk);
    ce <= 1'b1;
    rd(8'h04, img(1'b1, 2'b00, 1'b0, 2'b00, 2'b00, 4'ha), "csr frozen");
    @(posedge mclk);
    info <= 4'h5;
    wr(8'h04, 32'h0000_0c00, 2'b11);
    n = 0;
    while (iface_dc_low_line_n === 1'b0 && n < 64) begin
      n++;
      @(negedge mclk);
    end
    chk("dc low cycles", n, 32'(bnic_pkg::DC_LOW_CYCLES));
    n = 0;
    repeat (3) begin
      n += int'(selftest_reload === 1'b1);
      @(negedge mclk);
    end
    chk("reload", n, 1);
    repeat (12) @(posedge mclk);
    rd(8'h04, img(1'b1, 2'b00, 1'b0, 2'b00, 2'b00, 4'h5), "csr reinit");
    wr(8'h04, 32'h0, 2'b11);
    chk("drivers off", {31'h0, bus_drivers_en}, 32'h0);
    wr(8'h04, 32'h0000_0800, 2'b10);
    rd(8'h04, img(1'b0, 2'b00, 1'b0, 2'b00, 2'b00, 4'h5), "csr refused");
    complete_run();
  end
endmodule

//--- bench/bnic_master_model.sv
// Far-side model: master port event pulses and the self-test results that follow a reload.
`timescale 1ns/100ps
module bnic_master_model (
  input wire logic mclk,
  input wire logic mrst_n,
  input wire logic selftest_reload,
  input wire logic [2:0] ev_req,
  output bnic_pkg::bnic_mst_s mst,
  output logic iface_selftest_pass,
  output logic port_selftest_pass
);
  logic [2:0] dly;
  logic powered;
  // Each event request becomes one registered pulse, as a finished bus transaction would.
  always_ff @(posedge mclk or negedge mrst_n) begin
    if (!mrst_n) begin
      mst <= '0;
    end else begin
      mst <= '{ev_req[0], ev_req[1], ev_req[2]};
    end
  end
  // The port test runs at power up only, so later reloads report just the interface test.
  always_ff @(posedge mclk or negedge mrst_n) begin
    if (!mrst_n) begin
      dly <= 3'h0;
      powered <= 1'b0;
      iface_selftest_pass <= 1'b0;
      port_selftest_pass <= 1'b0;
    end else begin
      iface_selftest_pass <= (dly == 3'h1);
      port_selftest_pass <= (dly == 3'h1) && !powered;
      if (dly == 3'h1) begin
        powered <= 1'b1;
      end
      if (selftest_reload) begin
        dly <= 3'h4;
      end else if (dly != 3'h0) begin
        dly <= dly - 3'h1;
      end
    end
  end
endmodule

//--- pkg/bnic_pkg.sv
// Shared constants, field positions and carrier types for the node identification registers.
package bnic_pkg;

  // Register byte offsets inside the node's required register space.
  localparam logic [7:0] OFF_NODE_TYPE_INFO = 8'h00;
  localparam logic [7:0] OFF_BUS_IFACE_CSR = 8'h04;

  // Node-type register field positions.
  localparam int NT_TYPE_LSB = 0;
  localparam int NT_TYPE_MSB = 15;
  localparam int NT_PORT_REV_LSB = 16;
  localparam int NT_PORT_REV_MSB = 23;
  localparam int NT_LINK_REV_LSB = 24;
  localparam int NT_LINK_REV_MSB = 28;
  localparam int NT_RSVD_BIT = 29;
  localparam int NT_BUF_SIZE_BIT = 30;
  localparam int NT_DUPLEX_BIT = 31;

  // Control/status register field positions.
  localparam int CS_IF_REV_LSB = 24;
  localparam int CS_IF_REV_MSB = 31;
  localparam int CS_IF_TYPE_LSB = 16;
  localparam int CS_IF_TYPE_MSB = 23;
  localparam int CS_HARD_SUM_BIT = 15;
  localparam int CS_SOFT_SUM_BIT = 14;
  localparam int CS_UNUSED_BIT = 13;
  localparam int CS_FAILED_BIT = 12;
  localparam int CS_PASSED_BIT = 11;
  localparam int CS_REINIT_BIT = 10;
  localparam int CS_MBZ_BIT = 9;
  localparam int CS_UNLOCK_PEND_BIT = 8;
  localparam int CS_HARD_IE_BIT = 7;
  localparam int CS_SOFT_IE_BIT = 6;
  localparam int CS_GRANT_LSB = 4;
  localparam int CS_GRANT_MSB = 5;
  localparam int CS_NODE_ID_LSB = 0;
  localparam int CS_NODE_ID_MSB = 3;

  // Widths of the error inputs taken from the bus error register.
  localparam int HARD_ERR_W = 15;
  localparam int SOFT_ERR_W = 3;

  // Length of the dc-low pulse produced by a node reinitialisation, in clock cycles.
  localparam logic [7:0] DC_LOW_CYCLES = 8'h10;

  // Reset values of the read-only and reloaded fields.
  localparam logic [15:0] NODE_TYPE_CODE = 16'h5a3c; // Arbitrary value.
  localparam logic [7:0] IFACE_REVISION = 8'h3c; // Arbitrary value.
  localparam logic [7:0] IFACE_TYPE_CODE = 8'h5a; // Arbitrary value.
  localparam logic [7:0] PORT_REV_RESET = 8'h00;
  localparam logic [4:0] LINK_REV_RESET = 5'h00;
  localparam logic BUF_SIZE_RESET = 1'b0;
  localparam logic DUPLEX_RESET = 1'b0;

  typedef enum logic [1:0] {
    GRANT_DUAL_ROUND_ROBIN = 2'h0,
    GRANT_FIXED_HIGH = 2'h1,
    GRANT_FIXED_LOW = 2'h2,
    GRANT_DISABLED = 2'h3
  } bnic_grant_e;

  typedef enum logic [1:0] {
    SEQ_DC_LOW = 2'h1,
    SEQ_RUN = 2'h2
  } bnic_seq_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bnic_req_s;

  typedef struct packed {
    logic valid;
    logic ack;
    logic [31:0] rdata;
  } bnic_rsp_s;

  typedef struct packed {
    logic interlocked_read;
    logic unlocking_masked_write;
    logic unlock_attempt;
  } bnic_mst_s;

endpackage

//--- src/bnic_csr.sv
// Node identification and control/status registers of a backplane-bus node.
`timescale 1ns/100ps
module bnic_csr (
  input wire logic mclk,
  input wire logic mrst_n,
  input wire logic ce,
  input wire bnic_pkg::bnic_req_s req,
  output bnic_pkg::bnic_rsp_s rsp,
  input wire bnic_pkg::bnic_mst_s mst,
  input wire logic [bnic_pkg::HARD_ERR_W-1:0] hard_err_bits,
  input wire logic [bnic_pkg::SOFT_ERR_W-1:0] soft_err_bits,
  input wire logic iface_selftest_pass,
  input wire logic port_selftest_pass,
  input wire logic stop_cmd,
  input wire logic [3:0] iface_info_lines,
  output logic iface_dc_low_line_n,
  output logic selftest_reload,
  output logic bus_drivers_en,
  output logic interlock_sequence_fault,
  output logic hard_err_irq_req,
  output logic soft_err_irq_req,
  output logic [1:0] bus_grant_scheme
);

  logic dc_low;
  logic last_dc_cycle;
  logic dc_released;
  logic selftest_failed_flag;
  logic selftest_passed_flag;
  logic unlock_write_pending_flag;
  logic hard_ie;
  logic soft_ie;
  logic iface_pass_seen;
  logic port_pass_seen;
  logic [3:0] node_id;
  logic [7:0] port_rev;
  logic [4:0] link_rev;
  logic buf_size;
  logic duplex;
  logic hard_fault_summary;
  logic soft_fault_summary;
  logic hit_type;
  logic hit_csr;
  logic wr_type;
  logic wr_csr_raw;
  logic pass_violation;
  logic wr_csr;
  logic node_reinit_request;
  logic [31:0] node_type_info;
  logic [31:0] bus_iface_control_status;
  logic [7:0] rsp_addr;

  assign hard_fault_summary = |hard_err_bits;
  assign soft_fault_summary = |soft_err_bits;

  assign hit_type = (req.addr == bnic_pkg::OFF_NODE_TYPE_INFO);
  assign hit_csr = (req.addr == bnic_pkg::OFF_BUS_IFACE_CSR);
  assign wr_type = ce && req.valid && req.write && hit_type;
  assign wr_csr_raw = ce && req.valid && req.write && hit_csr;

  // A write that would set the pass flag while it is clear is refused whole.
  assign pass_violation = wr_csr_raw && !selftest_passed_flag
                          && req.wdata[bnic_pkg::CS_PASSED_BIT];
  assign wr_csr = wr_csr_raw && !pass_violation;
  assign node_reinit_request = wr_csr && req.wdata[bnic_pkg::CS_REINIT_BIT];

  bnic_dc_seq u_dc_seq (
    .mclk(mclk),
    .mrst_n(mrst_n),
    .ce(ce),
    .start(node_reinit_request),
    .dc_low(dc_low),
    .last_cycle(last_dc_cycle),
    .released(dc_released)
  );

  assign iface_dc_low_line_n = !dc_low;
  assign selftest_reload = dc_released;
  assign bus_drivers_en = selftest_passed_flag;
  assign bus_grant_scheme = bus_iface_control_status[bnic_pkg::CS_GRANT_MSB:
                                                     bnic_pkg::CS_GRANT_LSB];

  // Revision, size and duplex fields are writable but reload on every dc-low.
  always_ff @(posedge mclk or negedge mrst_n) begin
    if (!mrst_n) begin
      port_rev <= bnic_pkg::PORT_REV_RESET;
      link_rev <= bnic_pkg::LINK_REV_RESET;
      buf_size <= bnic_pkg::BUF_SIZE_RESET;
      duplex <= bnic_pkg::DUPLEX_RESET;
    end else if (ce) begin
      if (dc_low) begin
        port_rev <= bnic_pkg::PORT_REV_RESET;
        link_rev <= bnic_pkg::LINK_REV_RESET;
        buf_size <= bnic_pkg::BUF_SIZE_RESET;
        duplex <= bnic_pkg::DUPLEX_RESET;
      end else if (wr_type) begin
        port_rev <= req.wdata[bnic_pkg::NT_PORT_REV_MSB:bnic_pkg::NT_PORT_REV_LSB];
        link_rev <= req.wdata[bnic_pkg::NT_LINK_REV_MSB:bnic_pkg::NT_LINK_REV_LSB];
        buf_size <= req.wdata[bnic_pkg::NT_BUF_SIZE_BIT];
        duplex <= req.wdata[bnic_pkg::NT_DUPLEX_BIT];
      end
    end
  end

  // The port self-test runs at power up only, so its result survives a reinitialisation.
  always_ff @(posedge mclk or negedge mrst_n) begin
    if (!mrst_n) begin
      port_pass_seen <= 1'b0;
    end else if (ce && port_selftest_pass) begin
      port_pass_seen <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge mrst_n) begin
    if (!mrst_n) begin
      iface_pass_seen <= 1'b0;
    end else if (ce) begin
      if (dc_low) begin
        iface_pass_seen <= 1'b0;
      end else if (iface_selftest_pass) begin
        iface_pass_seen <= 1'b1;
      end
    end
  end

  // The pass flag clears under dc-low and a passing result wins over a write.
  always_ff @(posedge mclk or negedge mrst_n) begin
    if (!mrst_n) begin
      selftest_passed_flag <= 1'b0;
    end else if (ce) begin
      if (dc_low) begin
        selftest_passed_flag <= 1'b0;
      end else if (iface_selftest_pass) begin
        selftest_passed_flag <= 1'b1;
      end else if (wr_csr) begin
        selftest_passed_flag <= req.wdata[bnic_pkg::CS_PASSED_BIT];
      end
    end
  end

  // Failure flag sets under dc-low; that set outranks every clear.
  always_ff @(posedge mclk or negedge mrst_n) begin
    if (!mrst_n) begin
      selftest_failed_flag <= 1'b1;
    end else if (ce) begin
      if (dc_low) begin
        selftest_failed_flag <= 1'b1;
      end else if (iface_pass_seen && port_pass_seen) begin
        selftest_failed_flag <= 1'b0;
      end else if (wr_csr && req.wdata[bnic_pkg::CS_FAILED_BIT]) begin
        selftest_failed_flag <= 1'b0;
      end
    end
  end

  // An interlocked read in the same cycle as an unlocking write or a software clear leaves the flag set.
  always_ff @(posedge mclk or negedge mrst_n) begin
    if (!mrst_n) begin
      unlock_write_pending_flag <= 1'b0;
    end else if (ce) begin
      if (dc_low) begin
        unlock_write_pending_flag <= 1'b0;
      end else if (mst.interlocked_read) begin
        unlock_write_pending_flag <= 1'b1;
      end else if (mst.unlocking_masked_write) begin
        unlock_write_pending_flag <= 1'b0;
      end else if (wr_csr && req.wdata[bnic_pkg::CS_UNLOCK_PEND_BIT]) begin
        unlock_write_pending_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge mrst_n) begin
    if (!mrst_n) begin
      interlock_sequence_fault <= 1'b0;
    end else if (ce) begin
      interlock_sequence_fault <= mst.unlock_attempt && !unlock_write_pending_flag;
    end
  end

  // Interrupt enables clear on dc-low and on a stop command.
  always_ff @(posedge mclk or negedge mrst_n) begin
    if (!mrst_n) begin
      hard_ie <= 1'b0;
      soft_ie <= 1'b0;
    end else if (ce) begin
      if (dc_low || stop_cmd) begin
        hard_ie <= 1'b0;
        soft_ie <= 1'b0;
      end else if (wr_csr) begin
        hard_ie <= req.wdata[bnic_pkg::CS_HARD_IE_BIT];
        soft_ie <= req.wdata[bnic_pkg::CS_SOFT_IE_BIT];
      end
    end
  end

  always_ff @(posedge mclk or negedge mrst_n) begin
    if (!mrst_n) begin
      hard_err_irq_req <= 1'b0;
      soft_err_irq_req <= 1'b0;
    end else if (ce) begin
      hard_err_irq_req <= hard_ie && hard_fault_summary;
      soft_err_irq_req <= soft_ie && soft_fault_summary;
    end
  end

  // Reserved grant codes are stored as written; software keeps the field at zero.
  logic [1:0] grant_mode;
  always_ff @(posedge mclk or negedge mrst_n) begin
    if (!mrst_n) begin
      grant_mode <= bnic_pkg::GRANT_DUAL_ROUND_ROBIN;
    end else if (ce) begin
      if (dc_low) begin
        grant_mode <= bnic_pkg::GRANT_DUAL_ROUND_ROBIN;
      end else if (wr_csr) begin
        grant_mode <= req.wdata[bnic_pkg::CS_GRANT_MSB:bnic_pkg::CS_GRANT_LSB];
      end
    end
  end

  always_ff @(posedge mclk or negedge mrst_n) begin
    if (!mrst_n) begin
      node_id <= 4'h0;
    end else if (ce && last_dc_cycle) begin
      node_id <= iface_info_lines;
    end
  end

  // Read images; the reinit bit, bit 13 and the must-be-zero bits always read zero.
  always_comb begin
    node_type_info = 32'h0000_0000;
    node_type_info[bnic_pkg::NT_TYPE_MSB:bnic_pkg::NT_TYPE_LSB] = bnic_pkg::NODE_TYPE_CODE;
    node_type_info[bnic_pkg::NT_PORT_REV_MSB:bnic_pkg::NT_PORT_REV_LSB] = port_rev;
    node_type_info[bnic_pkg::NT_LINK_REV_MSB:bnic_pkg::NT_LINK_REV_LSB] = link_rev;
    node_type_info[bnic_pkg::NT_RSVD_BIT] = 1'b0;
    node_type_info[bnic_pkg::NT_BUF_SIZE_BIT] = buf_size;
    node_type_info[bnic_pkg::NT_DUPLEX_BIT] = duplex;
  end

  always_comb begin
    bus_iface_control_status = 32'h0000_0000;
    bus_iface_control_status[bnic_pkg::CS_IF_REV_MSB:bnic_pkg::CS_IF_REV_LSB] =
      bnic_pkg::IFACE_REVISION;
    bus_iface_control_status[bnic_pkg::CS_IF_TYPE_MSB:bnic_pkg::CS_IF_TYPE_LSB] =
      bnic_pkg::IFACE_TYPE_CODE;
    bus_iface_control_status[bnic_pkg::CS_HARD_SUM_BIT] = hard_fault_summary;
    bus_iface_control_status[bnic_pkg::CS_SOFT_SUM_BIT] = soft_fault_summary;
    bus_iface_control_status[bnic_pkg::CS_UNUSED_BIT] = 1'b0;
    bus_iface_control_status[bnic_pkg::CS_FAILED_BIT] = selftest_failed_flag;
    bus_iface_control_status[bnic_pkg::CS_PASSED_BIT] = selftest_passed_flag;
    bus_iface_control_status[bnic_pkg::CS_REINIT_BIT] = 1'b0;
    bus_iface_control_status[bnic_pkg::CS_MBZ_BIT] = 1'b0;
    bus_iface_control_status[bnic_pkg::CS_UNLOCK_PEND_BIT] = unlock_write_pending_flag;
    bus_iface_control_status[bnic_pkg::CS_HARD_IE_BIT] = hard_ie;
    bus_iface_control_status[bnic_pkg::CS_SOFT_IE_BIT] = soft_ie;
    bus_iface_control_status[bnic_pkg::CS_GRANT_MSB:bnic_pkg::CS_GRANT_LSB] = grant_mode;
    bus_iface_control_status[bnic_pkg::CS_NODE_ID_MSB:bnic_pkg::CS_NODE_ID_LSB] = node_id;
  end

  // Every request taken while ce is high is answered one cycle later; unmapped offsets get a no-acknowledge.
  always_ff @(posedge mclk or negedge mrst_n) begin
    if (!mrst_n) begin
      rsp <= '0;
      rsp_addr <= 8'h00;
    end else if (ce) begin
      rsp.valid <= req.valid;
      rsp.ack <= req.valid && (hit_type || hit_csr) && !pass_violation;
      rsp_addr <= req.addr;
      if (req.valid && !req.write && hit_type) begin
        rsp.rdata <= node_type_info;
      end else if (req.valid && !req.write && hit_csr) begin
        rsp.rdata <= bus_iface_control_status;
      end else begin
        rsp.rdata <= 32'h0000_0000;
      end
    end
  end

  property p_pass_noack;
    @(posedge mclk) disable iff (!mrst_n)
    pass_violation |=> (rsp.valid && !rsp.ack);
  endproperty
  a_pass_noack: assert property (p_pass_noack) else $error("pass flag set acknowledged");

  property p_reinit_dc_low;
    @(posedge mclk) disable iff (!mrst_n)
    (node_reinit_request && !dc_low) |=> !iface_dc_low_line_n [*8];
  endproperty
  a_reinit_dc_low: assert property (p_reinit_dc_low) else $error("dc-low too short");

  property p_drivers_off;
    @(posedge mclk) disable iff (!mrst_n)
    (ce && dc_low) |=> (!bus_drivers_en && selftest_failed_flag);
  endproperty
  a_drivers_off: assert property (p_drivers_off) else $error("drivers on after dc-low");

  property p_reload_after_release;
    @(posedge mclk) disable iff (!mrst_n)
    (ce && last_dc_cycle) |=> (selftest_reload && iface_dc_low_line_n);
  endproperty
  a_reload_after_release: assert property (p_reload_after_release)
    else $error("no reload pulse at release");

  property p_pending_set;
    @(posedge mclk) disable iff (!mrst_n)
    (ce && !dc_low && mst.interlocked_read) |=> unlock_write_pending_flag;
  endproperty
  a_pending_set: assert property (p_pending_set) else $error("pending flag not set");

  property p_seq_fault;
    @(posedge mclk) disable iff (!mrst_n)
    (ce && mst.unlock_attempt) |=> (interlock_sequence_fault == !$past(unlock_write_pending_flag));
  endproperty
  a_seq_fault: assert property (p_seq_fault) else $error("interlock fault mismatch");

  property p_node_id;
    @(posedge mclk) disable iff (!mrst_n)
    (ce && last_dc_cycle) |=> (node_id == $past(iface_info_lines));
  endproperty
  a_node_id: assert property (p_node_id) else $error("node id not captured");

  property p_hard_irq;
    @(posedge mclk) disable iff (!mrst_n)
    (ce && hard_ie && hard_fault_summary) |=> hard_err_irq_req;
  endproperty
  a_hard_irq: assert property (p_hard_irq) else $error("hard error interrupt missing");

  property p_type_read;
    @(posedge mclk) disable iff (!mrst_n)
    (rsp.valid && rsp.ack && rsp_addr == bnic_pkg::OFF_NODE_TYPE_INFO && rsp.rdata != 32'h0)
      |-> (rsp.rdata[bnic_pkg::NT_TYPE_MSB:bnic_pkg::NT_TYPE_LSB] == bnic_pkg::NODE_TYPE_CODE
           && !rsp.rdata[bnic_pkg::NT_RSVD_BIT]);
  endproperty
  a_type_read: assert property (p_type_read) else $error("node type code wrong");

  property p_csr_zero_bits;
    @(posedge mclk) disable iff (!mrst_n)
    (rsp.valid && rsp.ack && rsp_addr == bnic_pkg::OFF_BUS_IFACE_CSR && rsp.rdata != 32'h0)
      |-> (rsp.rdata[bnic_pkg::CS_UNUSED_BIT:bnic_pkg::CS_MBZ_BIT]
           == {1'b0, rsp.rdata[bnic_pkg::CS_FAILED_BIT:bnic_pkg::CS_PASSED_BIT], 2'b00});
  endproperty
  a_csr_zero_bits: assert property (p_csr_zero_bits) else $error("zero bits nonzero");

endmodule

//--- src/bnic_dc_seq.sv
// Dc-low sequencer: holds the interface dc-low line after power up or a reinitialisation.
`timescale 1ns/100ps
module bnic_dc_seq (
  input wire logic mclk,
  input wire logic mrst_n,
  input wire logic ce,
  input wire logic start,
  output logic dc_low,
  output logic last_cycle,
  output logic released
);

  bnic_pkg::bnic_seq_e state;
  logic [7:0] cnt;

  assign dc_low = (state == bnic_pkg::SEQ_DC_LOW);
  assign last_cycle = dc_low && (cnt == bnic_pkg::DC_LOW_CYCLES - 8'h01);

  // Power up counts as a dc-low period, so the node id is captured then too.
  always_ff @(posedge mclk or negedge mrst_n) begin
    if (!mrst_n) begin
      state <= bnic_pkg::SEQ_DC_LOW;
      cnt <= 8'h00;
    end else if (ce) begin
      case (state)
        bnic_pkg::SEQ_DC_LOW: begin
          if (last_cycle) begin
            state <= bnic_pkg::SEQ_RUN;
            cnt <= 8'h00;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        bnic_pkg::SEQ_RUN: begin
          if (start) begin
            state <= bnic_pkg::SEQ_DC_LOW;
            cnt <= 8'h00;
          end
        end
        default: begin
          state <= bnic_pkg::SEQ_DC_LOW;
          cnt <= 8'h00;
        end
      endcase
    end
  end

  // One pulse in the first cycle after the line is released.
  always_ff @(posedge mclk or negedge mrst_n) begin
    if (!mrst_n) begin
      released <= 1'b0;
    end else if (ce) begin
      released <= last_cycle;
    end
  end

endmodule
